// File: rtl/rcs_pkg.sv
// package: settings codes, ranges and initial values for the run command source logic
package rcs_pkg;
  // ----------------------------------------------------------------
  // command source codes
  // ----------------------------------------------------------------
  localparam logic [1:0] SRC_KEYPAD      = 2'h0;
  localparam logic [1:0] SRC_TERM_FWDREV = 2'h1;
  localparam logic [1:0] SRC_TERM_RUNDIR = 2'h2;
  localparam logic [1:0] SRC_SERIAL      = 2'h3;
  localparam logic [1:0] SRC_DEFAULT     = 2'h1;

  // ----------------------------------------------------------------
  // terminal function codes and counts
  // ----------------------------------------------------------------
  localparam logic [4:0] FUNC_FWD_RUN    = 5'h00;
  localparam logic [4:0] FUNC_REV_RUN    = 5'h01;
  localparam logic [4:0] FUNC_MAX        = 5'h1b;
  localparam logic [4:0] TERM1_FUNC_INIT = 5'h00;
  localparam logic [4:0] TERM2_FUNC_INIT = 5'h01;
  localparam int         TERM_COUNT      = 5;
  localparam int         TERM_STD_COUNT  = 3;

  // ----------------------------------------------------------------
  // direction lock, keypad direction, restart options
  // ----------------------------------------------------------------
  localparam logic [1:0] LOCK_NONE       = 2'h0;
  localparam logic [1:0] LOCK_FWD        = 2'h1;
  localparam logic [1:0] LOCK_REV        = 2'h2;
  localparam logic [1:0] LOCK_INIT       = 2'h0;
  localparam logic       KEYDIR_FWD      = 1'h0;
  localparam logic       KEYDIR_REV      = 1'h1;
  localparam logic       AUTORUN_INIT    = 1'h0;
  localparam logic       RESTART_INIT    = 1'h0;

  // ----------------------------------------------------------------
  // serial link settings
  // ----------------------------------------------------------------
  localparam logic [7:0] STATION_MIN     = 8'h01;
  localparam logic [7:0] STATION_MAX     = 8'hfa;
  localparam logic [7:0] STATION_INIT    = 8'h01;
  localparam logic [1:0] PROTO_MAX       = 2'h1;
  localparam logic [1:0] PROTO_INIT      = 2'h0;
  localparam logic [2:0] SPEED_MAX       = 3'h4;
  localparam logic [2:0] SPEED_INIT      = 3'h3;

  // ----------------------------------------------------------------
  // drive state, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_STOP = 4'h1,
    ST_FWD  = 4'h2,
    ST_REV  = 4'h4,
    ST_TRIP = 4'h8
  } rcs_state_t;

  // bounded-range check shared by the serial settings checks and the terminal function decode
  function automatic logic in_range8(input logic [7:0] v,
                                     input logic [7:0] lo,
                                     input logic [7:0] hi);
    return (v >= lo) && (v <= hi);
  endfunction
endpackage

// File: rtl/rcs_term_if.sv
// interface: terminal levels and functions in, decoded run commands out
`timescale 1ns/10ps
interface rcs_term_if;
  logic [4:0]      level;
  logic [4:0][4:0] func;
  logic            advanced;
  logic            fwd_cmd;
  logic            rev_cmd;
  modport dec  (input level, func, advanced, output fwd_cmd, rev_cmd);
  modport user (output level, func, advanced, input fwd_cmd, rev_cmd);
endinterface

// File: rtl/rcs_term_decode.sv
// module: maps multi-function terminals to forward and reverse run commands
`timescale 1ns/10ps
module rcs_term_decode (
  rcs_term_if.dec tif
);
  logic fwd_any;
  logic rev_any;

  // ----------------------------------------------------------------
  // terminal function decode
  // ----------------------------------------------------------------
  // function codes decode
  always_comb begin
    fwd_any = 1'b0;
    rev_any = 1'b0;
    for (int i = 0; i < rcs_pkg::TERM_COUNT; i++) begin
      // terminals above the third exist only on advanced models
      if ((i < rcs_pkg::TERM_STD_COUNT || tif.advanced) && tif.level[i] &&
          rcs_pkg::in_range8({3'h0, tif.func[i]}, 8'h00, {3'h0, rcs_pkg::FUNC_MAX})) begin
        if (tif.func[i] == rcs_pkg::FUNC_FWD_RUN) fwd_any = 1'b1;
        if (tif.func[i] == rcs_pkg::FUNC_REV_RUN) rev_any = 1'b1;
      end
    end
  end

  assign tif.fwd_cmd = fwd_any;
  assign tif.rev_cmd = rev_any;
endmodule // rcs_term_decode

// File: rtl/rcs_run_cmd.sv
// module: run command source selection, direction lock and restart control
`timescale 1ns/10ps
module rcs_run_cmd (
  input  wire logic       clock,
  input  wire logic       rstn,
  input  wire logic [1:0] command_source_select,
  input  wire logic       advanced_io,
  input  wire logic [4:0] input_terminal,
  input  wire logic [4:0] terminal1_function,
  input  wire logic [4:0] terminal2_function,
  input  wire logic [4:0] terminal3_function,
  input  wire logic [4:0] terminal4_function,
  input  wire logic [4:0] terminal5_function,
  input  wire logic       keypad_run_key,
  input  wire logic       keypad_stop_key,
  input  wire logic       keypad_direction,
  input  wire logic       serial_run,
  input  wire logic       serial_reverse,
  input  wire logic [7:0] station_number,
  input  wire logic [1:0] protocol_select,
  input  wire logic [2:0] speed_select,
  input  wire logic [1:0] direction_lock,
  input  wire logic       power_on_autorun,
  input  wire logic       trip_reset_restart,
  input  wire logic       fault_trip,
  input  wire logic       trip_reset_terminal,
  input  wire logic       trip_reset_keypad,
  output logic            motor_run_fwd,
  output logic            motor_run_rev,
  output logic            trip_latched,
  output logic            direction_blocked,
  output logic            serial_config_error
);
  rcs_term_if         tif ();
  rcs_pkg::rcs_state_t state_reg;
  rcs_pkg::rcs_state_t state_next;
  logic               first_reg;
  logic               armed_reg;
  logic               armed_next;
  logic               key_run_reg;
  logic               cfg_ok;
  logic               term_run;
  logic               req_run;
  logic               req_rev;
  logic               blocked;
  logic               trip_clear;

  // ----------------------------------------------------------------
  // terminal decoder
  // ----------------------------------------------------------------
  assign tif.level    = input_terminal;
  assign tif.func     = {terminal5_function, terminal4_function, terminal3_function,
                         terminal2_function, terminal1_function};
  assign tif.advanced = advanced_io;

  rcs_term_decode u_decode (
    .tif (tif.dec)
  );

  // ----------------------------------------------------------------
  // serial settings check
  // ----------------------------------------------------------------
  // serial settings range
  assign cfg_ok = rcs_pkg::in_range8(station_number, rcs_pkg::STATION_MIN,
                                     rcs_pkg::STATION_MAX) &&
                  rcs_pkg::in_range8({6'h00, protocol_select}, 8'h00,
                                     {6'h00, rcs_pkg::PROTO_MAX}) &&
                  rcs_pkg::in_range8({5'h00, speed_select}, 8'h00,
                                     {5'h00, rcs_pkg::SPEED_MAX});

  // ----------------------------------------------------------------
  // terminal run request, before the arming gate
  // ----------------------------------------------------------------
  always_comb begin
    term_run = 1'b0;
    if (command_source_select == rcs_pkg::SRC_TERM_FWDREV) term_run = tif.fwd_cmd ^ tif.rev_cmd;
    if (command_source_select == rcs_pkg::SRC_TERM_RUNDIR) term_run = tif.fwd_cmd;
  end

  // ----------------------------------------------------------------
  // source selection
  // ----------------------------------------------------------------
  always_comb begin
    req_run = 1'b0;
    req_rev = 1'b0;
    unique case (command_source_select)
      rcs_pkg::SRC_KEYPAD: begin
        req_run = key_run_reg;
        req_rev = (keypad_direction == rcs_pkg::KEYDIR_REV);
      end
      rcs_pkg::SRC_TERM_FWDREV: begin
        req_run = term_run && armed_reg;
        req_rev = tif.rev_cmd;
      end
      rcs_pkg::SRC_TERM_RUNDIR: begin
        req_run = term_run && armed_reg;
        req_rev = tif.rev_cmd;
      end
      rcs_pkg::SRC_SERIAL: begin
        req_run = advanced_io && cfg_ok && serial_run;
        req_rev = serial_reverse;
      end
    endcase
  end

  assign blocked = req_run &&
                   ((req_rev && direction_lock == rcs_pkg::LOCK_REV) ||
                    (!req_rev && direction_lock == rcs_pkg::LOCK_FWD));

  // ----------------------------------------------------------------
  // trip latch: a new fault beats a simultaneous reset
  // ----------------------------------------------------------------
  assign trip_clear = trip_latched && (trip_reset_terminal || trip_reset_keypad) && !fault_trip;

  always_ff @(posedge clock) begin
    if (!rstn) begin
      trip_latched <= 1'b0;
    end else if (fault_trip) begin
      trip_latched <= 1'b1;
    end else if (trip_clear) begin
      trip_latched <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // keypad run latch; stop key wins for safety
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rstn) begin
      key_run_reg <= 1'b0;
    end else if (keypad_stop_key || fault_trip || trip_latched ||
                 command_source_select != rcs_pkg::SRC_KEYPAD) begin
      key_run_reg <= 1'b0;
    end else if (keypad_run_key) begin
      key_run_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // arming: a terminal run held through power-up or a trip needs a
  // fresh assertion unless the matching option allows the start
  // ----------------------------------------------------------------
  always_comb begin
    armed_next = armed_reg;
    if (!term_run) begin
      armed_next = 1'b1;
    end else if (first_reg) begin
      armed_next = power_on_autorun;
    end else if (fault_trip) begin
      armed_next = 1'b0;
    end else if (trip_clear) begin
      armed_next = trip_reset_restart;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      armed_reg <= 1'b0;
      first_reg <= 1'b1;
    end else begin
      armed_reg <= armed_next;
      first_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // drive state
  // ----------------------------------------------------------------
  always_comb begin
    if (fault_trip || trip_latched) begin
      state_next = rcs_pkg::ST_TRIP;
    end else if (req_run && !blocked) begin
      state_next = req_rev ? rcs_pkg::ST_REV : rcs_pkg::ST_FWD;
    end else begin
      state_next = rcs_pkg::ST_STOP;
    end
  end

  // outputs registered together with the state so they never glitch
  always_ff @(posedge clock) begin
    if (!rstn) begin
      state_reg           <= rcs_pkg::ST_STOP;
      motor_run_fwd       <= 1'b0;
      motor_run_rev       <= 1'b0;
      direction_blocked   <= 1'b0;
      serial_config_error <= 1'b0;
    end else begin
      state_reg           <= state_next;
      motor_run_fwd       <= (state_next == rcs_pkg::ST_FWD);
      motor_run_rev       <= (state_next == rcs_pkg::ST_REV);
      direction_blocked   <= blocked;
      serial_config_error <= !cfg_ok;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  fwdrev_fwd_a: assert property (
    command_source_select == rcs_pkg::SRC_TERM_FWDREV && tif.fwd_cmd && !tif.rev_cmd &&
    armed_reg && !fault_trip && !trip_latched && direction_lock == rcs_pkg::LOCK_NONE
    |=> motor_run_fwd && !motor_run_rev) else $error("forward command did not run forward");
  fwdrev_both_a: assert property (
    command_source_select == rcs_pkg::SRC_TERM_FWDREV && tif.fwd_cmd == tif.rev_cmd
    |=> !motor_run_fwd && !motor_run_rev) else $error("equal commands did not stop");
  rundir_fwd_a: assert property (
    command_source_select == rcs_pkg::SRC_TERM_RUNDIR && tif.fwd_cmd && !tif.rev_cmd &&
    armed_reg && !fault_trip && !trip_latched && direction_lock == rcs_pkg::LOCK_NONE
    |=> motor_run_fwd) else $error("run without direction did not run forward");
  rundir_rev_a: assert property (
    command_source_select == rcs_pkg::SRC_TERM_RUNDIR && tif.fwd_cmd && tif.rev_cmd &&
    armed_reg && !fault_trip && !trip_latched && direction_lock == rcs_pkg::LOCK_NONE
    |=> motor_run_rev) else $error("run with direction did not run reverse");
  lock_fwd_a: assert property (
    direction_lock == rcs_pkg::LOCK_FWD |=> !motor_run_fwd)
    else $error("forward ran while locked");
  lock_hold_a: assert property (
    blocked |=> !motor_run_fwd && !motor_run_rev && direction_blocked)
    else $error("forbidden request not held stopped");
  serial_std_a: assert property (
    command_source_select == rcs_pkg::SRC_SERIAL && !advanced_io
    |=> !motor_run_fwd && !motor_run_rev) else $error("serial ran on standard model");
  keypad_stop_a: assert property (
    command_source_select == rcs_pkg::SRC_KEYPAD && keypad_stop_key
    |=> ##1 !motor_run_fwd && !motor_run_rev) else $error("stop key did not stop");
  autorun_off_a: assert property (
    first_reg && term_run && !power_on_autorun |=> !armed_reg)
    else $error("terminal run armed at power-up without autorun");
  restart_a: assert property (
    trip_clear && term_run && trip_reset_restart |=> armed_reg)
    else $error("restart not armed after trip reset");
  trip_stop_a: assert property (
    fault_trip |=> trip_latched && !motor_run_fwd && !motor_run_rev)
    else $error("fault did not stop and latch");
  cfg_err_a: assert property (
    station_number == 8'h00 |=> serial_config_error) else $error("station 0 accepted");

  run_fwd_c: cover property (!motor_run_fwd ##1 motor_run_fwd);
  run_rev_c: cover property (motor_run_fwd ##1 motor_run_rev);
  trip_restart_c: cover property (trip_clear && trip_reset_restart ##1 !trip_latched);
endmodule // rcs_run_cmd

// File: verification/rcs_far_side.sv
// far-side model: terminal switches and serial host feeding the run command logic
`timescale 1ns/10ps
module rcs_far_side (
  input  wire logic       clock,
  input  wire logic [4:0] sw_req,
  input  wire logic       host_run,
  input  wire logic       host_rev,
  input  wire logic [7:0] host_station,
  input  wire logic [1:0] host_proto,
  input  wire logic [2:0] host_speed,
  output logic      [4:0] input_terminal,
  output logic            serial_run,
  output logic            serial_reverse,
  output logic      [7:0] station_number,
  output logic      [1:0] protocol_select,
  output logic      [2:0] speed_select
);
  // ----------------------------------------------------------------
  // contacts and host
  // ----------------------------------------------------------------
  // idle at power-up: contacts open, host settings at their initial values
  initial begin
    input_terminal  = 5'h00;
    serial_run      = 1'h0;
    serial_reverse  = 1'h0;
    station_number  = rcs_pkg::STATION_INIT;
    protocol_select = rcs_pkg::PROTO_INIT;
    speed_select    = rcs_pkg::SPEED_INIT;
  end

  // contacts pick up one cycle late, which is kinder than real bounce but keeps timing fixed
  always @(posedge clock) begin
    input_terminal <= #1 sw_req;
  end

  always @(posedge clock) begin
    serial_run      <= #1 host_run;
    serial_reverse  <= #1 host_rev;
    station_number  <= #1 host_station;
    protocol_select <= #1 host_proto;
    speed_select    <= #1 host_speed;
  end
endmodule // rcs_far_side

// File: verification/rcs_run_cmd_tb.sv
// testbench: run command source logic against a behavioural model
`timescale 1ns/10ps
module rcs_run_cmd_tb;
  logic            clock = 1'b0;
  logic            rstn = 1'b0;
  logic [1:0]      src = 2'h1;
  logic            adv = 1'h1;
  logic [4:0][4:0] fn = {5'h04, 5'h03, 5'h02, 5'h01, 5'h00};
  logic [4:0]      sw = 5'h00;
  logic            key_run = 1'h0, key_stop = 1'h0, key_dir = 1'h0;
  logic            host_run = 1'h0, host_rev = 1'h0;
  logic [7:0]      stn = 8'h01;
  logic [1:0]      proto = 2'h0, lock = 2'h0;
  logic [2:0]      spd = 3'h3;
  logic            autorun = 1'h0, restart = 1'h0, fault = 1'h0;
  logic            rst_term = 1'h0, rst_key = 1'h0;
  logic [4:0]      term;
  logic            s_run, s_rev, fwd, rev, trip, blk, cfg_err;
  logic [7:0]      station;
  logic [1:0]      proto_w;
  logic [2:0]      spd_w;
  logic [31:0]     v;
  int              num_errors = 0, cmp_count = 0, seed = 27, cycles = 0;

  always #5 clock = ~clock;

  rcs_far_side u_rcs_far_side (.clock(clock), .sw_req(sw), .host_run(host_run),
    .host_rev(host_rev), .host_station(stn), .host_proto(proto), .host_speed(spd),
    .input_terminal(term), .serial_run(s_run), .serial_reverse(s_rev),
    .station_number(station), .protocol_select(proto_w), .speed_select(spd_w));

  rcs_run_cmd u_rcs_run_cmd (.clock(clock), .rstn(rstn), .command_source_select(src),
    .advanced_io(adv), .input_terminal(term), .terminal1_function(fn[0]),
    .terminal2_function(fn[1]), .terminal3_function(fn[2]), .terminal4_function(fn[3]),
    .terminal5_function(fn[4]), .keypad_run_key(key_run), .keypad_stop_key(key_stop),
    .keypad_direction(key_dir), .serial_run(s_run), .serial_reverse(s_rev),
    .station_number(station), .protocol_select(proto_w), .speed_select(spd_w),
    .direction_lock(lock), .power_on_autorun(autorun), .trip_reset_restart(restart),
    .fault_trip(fault), .trip_reset_terminal(rst_term), .trip_reset_keypad(rst_key),
    .motor_run_fwd(fwd), .motor_run_rev(rev), .trip_latched(trip),
    .direction_blocked(blk), .serial_config_error(cfg_err));

  // ----------------------------------------------------------------
  // reference model
  // ----------------------------------------------------------------
  function automatic logic bad_cfg();
    return station < 8'h01 || station > 8'hfa || proto_w > 2'h1 || spd_w > 3'h4;
  endfunction

  // expected {fwd, rev, blocked} once armed and with no trip pending
  function automatic logic [2:0] model(input logic latch);
    logic f = 1'b0, r = 1'b0, req, dir;
    for (int i = 0; i < 5; i++) begin
      if (term[i] && (i < 3 || adv)) begin
        if (fn[i] == 5'h00) f = 1'b1;
        if (fn[i] == 5'h01) r = 1'b1;
      end
    end
    case (src)
      2'h0: begin req = latch; dir = key_dir; end
      2'h1: begin req = f ^ r; dir = r; end
      2'h2: begin req = f; dir = r; end
      default: begin req = adv && !bad_cfg() && s_run; dir = s_rev; end
    endcase
    if (req && ((lock == 2'h1 && !dir) || (lock == 2'h2 && dir))) return 3'b001;
    return req ? (dir ? 3'b010 : 3'b100) : 3'b000;
  endfunction

  // ----------------------------------------------------------------
  // checks and sequencing
  // ----------------------------------------------------------------
  task automatic chk_run(input string what, input logic [2:0] exp);
    cmp_count++;
    if ({fwd, rev, blk} !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, {fwd, rev, blk});
    end
  endtask

  task automatic chk_flag(input string what, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask

  // inputs always move 1 ns after the rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // hang guard, well above the roughly 460 cycles the run needs
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      $display("timeout reached");
      conclude();
    end
  end

  initial begin
    tick(20);
    chk_run("reset run", 3'b000);
    chk_flag("reset trip", 1'b0, trip);
    rstn = 1'b1;
    tick(4);
    for (int k = 0; k < 80; k++) begin
      v = $random(seed);
      src = 2'h1 + 2'(v[3:0] % 3);
      {lock, adv, host_run, host_rev, key_dir} = v[9:4];
      sw = v[14:10];
      for (int i = 0; i < 5; i++) fn[i] = (v[15+i]) ? 5'(v[20+i]) : 5'h1b;
      stn = (v[25]) ? 8'h01 + 8'(v[31:26] % 4) * 8'h53 : 8'(v[31:26]) + 8'hf8;
      // protocol codes 2 and 3 are out of range and must flag the settings
      {proto, spd} = {v[27:26], 3'(v[30:28] % 6)};
      tick(4);
      chk_run("decode", model(1'b0));
      chk_flag("config error", bad_cfg(), cfg_err);
    end
    // station 0 may never come up at random, so force it once
    {stn, proto, spd} = {8'h00, 2'h0, 3'h3};
    tick(4);
    chk_flag("station zero", 1'b1, cfg_err);
    stn = 8'h01;
    tick(4);
    chk_flag("station one", 1'b0, cfg_err);
    $display("test decode done");
    {src, lock, sw} = {2'h0, 2'h0, 5'h00};
    for (int d = 0; d < 2; d++) begin
      key_dir = d[0];
      key_run = 1'h1;
      tick(1);
      key_run = 1'h0;
      tick(4);
      chk_run("keypad run", model(1'b1));
      lock = d[0] ? 2'h2 : 2'h1;
      tick(4);
      chk_run("keypad lock", model(1'b1));
      lock = 2'h0;
      key_stop = 1'h1;
      tick(1);
      key_stop = 1'h0;
      tick(4);
      chk_run("keypad stop", model(1'b0));
    end
    $display("test keypad done");
    {src, fn[0], fn[1], sw} = {2'h1, 5'h00, 5'h01, 5'h01};
    tick(4);
    // restart after trip, reset from terminal or keypad
    for (int m = 0; m < 4; m++) begin
      restart = m[1];
      fault = 1'h1;
      tick(1);
      fault = 1'h0;
      tick(3);
      chk_flag("trip set", 1'b1, trip);
      chk_run("trip stop", 3'b000);
      {rst_key, rst_term} = m[0] ? 2'b10 : 2'b01;
      tick(1);
      {rst_key, rst_term} = 2'b00;
      tick(4);
      chk_flag("trip clear", 1'b0, trip);
      chk_run("restart", restart ? 3'b100 : 3'b000);
      sw = 5'h00;
      tick(3);
      sw = 5'h01;
      tick(4);
      chk_run("rearmed", 3'b100);
    end
    $display("test trip done");
    // terminal run already active at power-up
    for (int a = 0; a < 2; a++) begin
      autorun = a[0];
      rstn = 1'b0;
      tick(3);
      rstn = 1'b1;
      tick(4);
      chk_run("autorun", a ? 3'b100 : 3'b000);
    end
    $display("test autorun done");
    conclude();
  end
endmodule // rcs_run_cmd_tb
